// File: rtl/input_clock_gating.v
// external clock distribution and gating with apb control registers
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "clock_gating_map.vh"
module input_clock_gating
(
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_clock_pin,
  input wire addressLatchIdle,
  input wire specialFuncActive,
  output reg arrayClockEn,
  output reg macrocellClockEn,
  output reg apdClockEn,
  output reg timerClockEn,
  output reg timerTick,
  output reg inputBufferEn,
  output reg logicLowSpeed,
  output reg powerDown,
  output reg sleepActive,
  output reg ioHoldEn,
  output reg addrOutValid,
  output reg dataPortOe_n,
  output reg periphOe_n,
  output reg specialFuncOutEn
);

  // ********************************
  // pin synchronisers and clock activity
  // ********************************
  reg [1:0] extClkSync_q;
  reg extClkPrev_q;
  reg [1:0] aleSync_q;
  reg [3:0] idleCnt_q;
  reg clockRunning_q;
  wire extClkEdge;
  wire extClkSeen;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      extClkSync_q <= 2'b00;
      extClkPrev_q <= 1'b0;
      aleSync_q <= 2'b00;
    end
    else
    begin
      extClkSync_q <= {extClkSync_q[0], ext_clock_pin};
      extClkPrev_q <= extClkSeen;
      aleSync_q <= {aleSync_q[0], addressLatchIdle};
    end
  end

  // pin meets no gate before both flops; buffer switch acts on the synced level
  assign extClkSeen = extClkSync_q[1] & inputBufferEn;
  assign extClkEdge = extClkSeen & ~extClkPrev_q;

  // clock counts as running while edges were seen recently
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      idleCnt_q <= 4'h0;
      clockRunning_q <= 1'b0;
    end
    else if (extClkEdge)
    begin
      idleCnt_q <= 4'h0;
      clockRunning_q <= 1'b1;
    end
    else if (idleCnt_q != `CLK_IDLE_LIMIT)
    begin
      idleCnt_q <= idleCnt_q + 4'h1;
    end
    else
    begin
      clockRunning_q <= 1'b0;
    end
  end

  // ********************************
  // control registers
  // ********************************
  reg [7:0] pmc0_q;
  reg [7:0] pmc1_q;
  reg [7:0] delay_q;
  wire apbWrite;
  wire apbRead;

  assign apbWrite = psel & penable & pwrite & pready;
  assign apbRead = psel & ~penable & ~pwrite;

  function addrKnown;
    input [11:0] a;
    begin
      addrKnown = (a == `PMC0_ADDR) || (a == `PMC1_ADDR) ||
        (a == `DELAY_ADDR) || (a == `STATUS_ADDR);
    end
  endfunction

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pmc0_q <= `PMC0_RESET;
      pmc1_q <= `PMC1_RESET;
      delay_q <= `DELAY_RESET;
    end
    else if (apbWrite)
    begin
      case (paddr)
        `PMC0_ADDR: pmc0_q <= pwdata[7:0];
        `PMC1_ADDR: pmc1_q <= pwdata[7:0];
        `DELAY_ADDR: delay_q <= pwdata[7:0];
        default: pmc0_q <= pmc0_q;
      endcase
    end
  end

  // ********************************
  // apb answer: one wait-free access phase
  // ********************************
  wire [31:0] statusWord;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addrKnown(paddr);
      if (apbRead)
      begin
        case (paddr)
          `PMC0_ADDR: prdata <= {24'h00_0000, pmc0_q};
          `PMC1_ADDR: prdata <= {24'h00_0000, pmc1_q};
          `DELAY_ADDR: prdata <= {24'h00_0000, delay_q};
          `STATUS_ADDR: prdata <= statusWord;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ********************************
  // automatic power-down counter
  // ********************************
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_DOWN = 3'b010;
  localparam [2:0] ST_SLEEP = 3'b100;
  reg [2:0] state_q;
  reg [3:0] apdCnt_q;
  wire apdEnable;
  wire idleLevel;
  wire apdOverflow;

  assign apdEnable = pmc0_q[`PMC0_APD_EN_BIT];
  assign idleLevel = aleSync_q[1];
  assign apdOverflow = apdCnt_q == `APD_OVERFLOW_COUNT;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      apdCnt_q <= 4'h0;
      state_q <= ST_RUN;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (!apdEnable || !idleLevel)
          begin
            apdCnt_q <= 4'h0;
          end
          else if (apdOverflow)
          begin
            state_q <= pmc1_q[`PMC1_SLEEP_BIT] ? ST_SLEEP : ST_DOWN;
          end
          else if (extClkEdge)
          begin
            apdCnt_q <= apdCnt_q + 4'h1;
          end
        end
        ST_DOWN, ST_SLEEP:
        begin
          // bus activity wakes the device; counter frozen meanwhile
          if (!apdEnable || !idleLevel)
          begin
            apdCnt_q <= 4'h0;
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  assign statusWord = {26'h000_0000, clockRunning_q, inputBufferEn, apdOverflow,
    state_q};

  // ********************************
  // clock gates and pin states
  // ********************************
  wire standby;
  wire allGated;
  wire timerEnable;

  assign standby = (state_q != ST_RUN);
  assign allGated = pmc0_q[`PMC0_ARRAY_BIT] & pmc0_q[`PMC0_MACRO_BIT] &
    pmc0_q[`PMC0_TIMER_BIT];
  // timers keep running in sleep unless gated
  assign timerEnable = ~pmc0_q[`PMC0_TIMER_BIT] & extClkEdge;

  wire tickNext;

  timer_clock_divider divider
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(timerEnable),
    .delayCycles(delay_q),
    .timerTick(tickNext)
  );

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      arrayClockEn <= 1'b1;
      macrocellClockEn <= 1'b1;
      apdClockEn <= 1'b1;
      timerClockEn <= 1'b1;
      timerTick <= 1'b0;
      inputBufferEn <= 1'b1;
      logicLowSpeed <= 1'b0;
      powerDown <= 1'b0;
      sleepActive <= 1'b0;
    end
    else
    begin
      arrayClockEn <= ~pmc0_q[`PMC0_ARRAY_BIT];
      macrocellClockEn <= ~pmc0_q[`PMC0_MACRO_BIT];
      apdClockEn <= ~standby;
      timerClockEn <= ~pmc0_q[`PMC0_TIMER_BIT];
      timerTick <= tickNext;
      // buffer stays on until every gate is set and the counter overflowed
      inputBufferEn <= ~(allGated & apdOverflow);
      logicLowSpeed <= pmc0_q[`PMC0_TURBO_BIT];
      powerDown <= (state_q == ST_DOWN);
      sleepActive <= (state_q == ST_SLEEP);
    end
  end

  // ********************************
  // pin states in power down and sleep
  // ********************************
  wire sfDrive;

  // in power down and sleep, special-function pins go quiet once the clock input has stopped
  assign sfDrive = specialFuncActive & (~standby | clockRunning_q);

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ioHoldEn <= 1'b0;
      addrOutValid <= 1'b1;
      dataPortOe_n <= 1'b0;
      periphOe_n <= 1'b0;
      specialFuncOutEn <= 1'b1;
    end
    else
    begin
      ioHoldEn <= standby;
      addrOutValid <= ~standby;
      dataPortOe_n <= standby;
      periphOe_n <= standby;
      specialFuncOutEn <= sfDrive;
    end
  end

endmodule

// File: include/clock_gating_map.vh
// register offsets, field positions, reset values and timing counts of the clock gating block
`ifndef CLOCK_GATING_MAP_VH
`define CLOCK_GATING_MAP_VH

// ********************************
// register byte addresses
// ********************************
`define PMC0_ADDR 12'h000
`define PMC1_ADDR 12'h004
`define DELAY_ADDR 12'h008
`define STATUS_ADDR 12'h00C

// ********************************
// control register 0 fields
// ********************************
`define PMC0_APD_EN_BIT 2
`define PMC0_TURBO_BIT 4
`define PMC0_ARRAY_BIT 5
`define PMC0_MACRO_BIT 6
`define PMC0_TIMER_BIT 7
`define PMC0_RESET 8'h00

// ********************************
// control register 1 fields
// ********************************
`define PMC1_SLEEP_BIT 1
`define PMC1_RESET 8'h00

// ********************************
// timing
// ********************************
`define DELAY_RESET 8'h00
`define TIMER_PRESCALE 4
`define APD_OVERFLOW_COUNT 4'hF
`define CLK_IDLE_LIMIT 4'hF

`endif

// File: rtl/timer_clock_divider.v
// timer clock scaler: fixed divide by four then delay-cycle divide
`timescale 1ns/1ps
module timer_clock_divider
(
  input wire sys_clk,
  input wire rst,
  input wire enable,
  input wire [7:0] delayCycles,
  output reg timerTick
);

  reg [1:0] preCnt_q;
  reg [7:0] delayCnt_q;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      preCnt_q <= 2'h0;
      delayCnt_q <= 8'h00;
      timerTick <= 1'b0;
    end
    else
    begin
      timerTick <= 1'b0;
      if (enable)
      begin
        preCnt_q <= preCnt_q + 2'h1;
        // finest tick is input clock over four
        if (preCnt_q == 2'h3)
        begin
          if (delayCnt_q >= delayCycles)
          begin
            delayCnt_q <= 8'h00;
            timerTick <= 1'b1;
          end
          else
          begin
            delayCnt_q <= delayCnt_q + 8'h01;
          end
        end
      end
    end
  end

endmodule

// File: verification/ext_clock_source.sv
// partner model: free-running external clock source
`timescale 1ns/1ps
module ext_clock_source
(
  output logic clkOut
);
  // ****
  // oscillator
  // ****
  // odd start offset keeps it unrelated in phase to the core clock
  initial
  begin
    clkOut = 1'b0;
    #37;
    forever #200 clkOut = ~clkOut;
  end
endmodule

// File: verification/clock_gating_checker.sv
// assertion checker for the clock gating block
`timescale 1ns/1ps
module clock_gating_checker
(
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire arrayClockEn,
  input wire macrocellClockEn,
  input wire timerClockEn,
  input wire apdClockEn,
  input wire inputBufferEn,
  input wire powerDown,
  input wire sleepActive,
  input wire dataPortOe_n,
  input wire timerTick
);
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire wr0 = psel && penable && pready && pwrite && paddr == 12'h000;
  wire stby = powerDown || sleepActive;
  array_gate_a: assert property (wr0 && pwdata[5] |-> ##[1:2] !arrayClockEn)
    else $error("array gate");
  macro_gate_a: assert property (wr0 && pwdata[6] |-> ##[1:2] !macrocellClockEn)
    else $error("macro gate");
  timer_gate_a: assert property (wr0 && pwdata[7] |-> ##[1:2] !timerClockEn)
    else $error("timer gate");
  timer_open_a: assert property (wr0 && !pwdata[7] |-> ##[1:2] timerClockEn)
    else $error("timer open");
  apd_stop_a: assert property (stby [*2] |-> !apdClockEn)
    else $error("apd clock");
  buffer_off_a: assert property (!inputBufferEn |->
    !(arrayClockEn || macrocellClockEn || timerClockEn))
    else $error("buffer off");
  data_tristate_a: assert property (stby [*2] |-> dataPortOe_n)
    else $error("data port");
  tick_spacing_a: assert property (timerTick |=> !timerTick [*7])
    else $error("tick spacing");
  cover property (wr0 && pwdata[5]);
  cover property (sleepActive);
  cover property (!inputBufferEn);
endmodule

bind input_clock_gating clock_gating_checker u_chk (.*);

// File: verification/tb.sv
// self-checking bench for the clock gating block
`timescale 1ns/1ps
module tb;
  reg sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, idle = 0, sfa = 1;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, arrayClockEn, macrocellClockEn, apdClockEn, timerClockEn;
  wire timerTick, inputBufferEn, logicLowSpeed, powerDown, sleepActive, ioHoldEn;
  wire addrOutValid, dataPortOe_n, periphOe_n, specialFuncOutEn, extClk;
  wire [12:0] outs = {arrayClockEn, macrocellClockEn, apdClockEn, timerClockEn,
    inputBufferEn, powerDown, sleepActive, dataPortOe_n, periphOe_n, ioHoldEn,
    logicLowSpeed, addrOutValid, specialFuncOutEn};
  int err_total = 0, n_checks = 0, ticks = 0, e;
  logic [32:0] expQ[$];
  ext_clock_source u_src (.clkOut(extClk));
  input_clock_gating u_dut (.*, .ext_clock_pin(extClk), .addressLatchIdle(idle),
    .specialFuncActive(sfa));
  // ****
  // helpers
  // ****
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (timerTick) ticks++;
  always @(posedge sys_clk)
    if (psel && penable && pready && !pwrite)
      chk("read", expQ.pop_front(), {pslverr, prdata});
  task automatic chk(string nm, logic [32:0] ex, logic [32:0] g);
    n_checks++;
    if (g !== ex)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, ex, g);
    end
  endtask
  // request held until pready is seen high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] ex);
    expQ.push_back(ex);
    apb(0, a, 0);
  endtask
  task automatic span(int n, int ex);
    ticks = 0;
    repeat (n) @(posedge sys_clk);
    chk("ticks", 1, (ticks - ex) * (ticks - ex) <= 1);
  endtask
  task end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    #500000;
    err_total++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'hdadd));
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    chk("outs", 13'h1f03, outs);
    repeat (10) @(posedge sys_clk);
    rd(12'h00c, 33'h0_0000_0031);
    for (int b = 5; b < 8; b++)
    begin
      apb(1, 0, ($urandom << 8) | (32'h1 << b));
      repeat (2) @(posedge sys_clk);
      chk("outs", {b != 5, b != 6, 1'b1, b != 7, 9'h103}, outs);
      rd(0, 33'h1 << b);
    end
    apb(1, 12'h010, $urandom);
    rd(12'h010, 33'h1_0000_0000);
    for (int d = 0; d < 3; d++)
    begin
      apb(1, 12'h008, d % 2);
      apb(1, 0, (d / 2) << 7);
      e = (d == 2) ? 0 : 20 / (d + 1);
      span(320, e);
    end
    idle <= 1;
    apb(1, 0, 32'h0000_00f4);
    repeat (150) @(posedge sys_clk);
    chk("outs", 13'h00bc, outs);
    idle <= 0;
    apb(1, 12'h004, 32'h0000_0002);
    apb(1, 0, 32'h0000_0004);
    idle <= 1;
    repeat (150) @(posedge sys_clk);
    chk("outs", 13'h1b79, outs);
    span(160, 10);
    idle <= 0;
    sfa <= 0;
    repeat (10) @(posedge sys_clk);
    chk("outs", 13'h1f02, outs);
    end_sim();
  end
endmodule
